/* File: nis_map.svh */
// Constants of the target control block: opcodes, pin positions, timing
`ifndef NIS_MAP_SVH
`define NIS_MAP_SVH
// Sizes
`define NIS_TARGETS 2
`define NIS_CNT_W 20
// Clock and busy times (us), cycle counts derived from the clock rate
`define NIS_CLK_MHZ 40
`define NIS_T_POR_US 1000
`define NIS_T_RST_US 500
`define NIS_T_ITC_US 1
`define NIS_POR_CYC (`NIS_T_POR_US * `NIS_CLK_MHZ)
`define NIS_RST_CYC (`NIS_T_RST_US * `NIS_CLK_MHZ)
`define NIS_ITC_CYC (`NIS_T_ITC_US * `NIS_CLK_MHZ)
// Positions in the sampled pin vector {ce_b, cle, ale, we_clk, re_b, dq_in}
`define NIS_PIN_RE 8
`define NIS_PIN_WE 9
`define NIS_PIN_ALE 10
`define NIS_PIN_CLE 11
`define NIS_PIN_CE 12
// Status byte bits
`define NIS_SR_WPN 7
`define NIS_SR_RDY 6
`define NIS_SR_ARDY 5
// Feature address and first parameter interface nibble
`define NIS_FA_TIMING 8'h01
`define NIS_P1_SYNC 4'h1
// Opcodes
`define NIS_OP_RESET 8'hff
`define NIS_OP_SRESET 8'hfc
`define NIS_OP_LRESET 8'hfa
`define NIS_OP_STAT 8'h70
`define NIS_OP_STATE 8'h78
`define NIS_OP_SETF 8'hef
`define NIS_OP_READ 8'h00
`define NIS_OP_CCOL 8'h05
`define NIS_OP_CCOLE 8'h06
`define NIS_OP_CCONF 8'he0
`define NIS_OP_RCONF 8'h30
`define NIS_OP_CSEQ 8'h31
`define NIS_OP_RMP 8'h32
`define NIS_OP_CLAST 8'h3f
`define NIS_OP_PROG 8'h80
`define NIS_OP_PCONF 8'h10
`define NIS_OP_PMP 8'h11
`define NIS_OP_PCACHE 8'h15
`endif

/* File: nis_pkg.sv */
// Types of the target control block
`include "nis_map.svh"
package nis_pkg;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ADDR, SQ_WAIT2, SQ_DATA} nis_seq_t;
  typedef enum logic [1:0] {BK_NONE, BK_POR, BK_RST, BK_ITC} nis_busy_t;
  typedef enum logic [4:0] {OP_NONE, OP_RESET, OP_SYNC_RESET, OP_RESET_LUN, OP_STATUS, OP_STATUS_ENH,
    OP_SET_FEAT, OP_CHG_COL, OP_CHG_COL_ENH, OP_PAGE_READ, OP_READ_MP, OP_CACHE_SEQ, OP_CACHE_RAND,
    OP_CACHE_LAST, OP_PROG, OP_PROG_MP, OP_PROG_CACHE} nis_op_t;
  // Per-target control state
  typedef struct packed {
    logic booted;
    logic sync_mode;
    logic [7:0] p1;
    nis_seq_t seq;
    logic [7:0] cmd1;
    logic [2:0] acnt;
    logic [2:0] need;
    logic [2:0] dcnt;
    logic [7:0] fbyte;
    logic feat_tm;
    logic stat_sel;
    nis_busy_t kind;
    logic to_async;
    logic start;
    logic [`NIS_CNT_W-1:0] len;
  } nis_tgt_t;
  // Busy timer state
  typedef struct packed {
    logic busy;
    logic [`NIS_CNT_W-1:0] cnt;
    logic mark_hit;
    logic done;
  } nis_tmr_t;
endpackage : nis_pkg

/* File: nis_busy_if.sv */
// Carrier between the target decoder and one busy timer
`timescale 1ns/100ps
`include "nis_map.svh"
interface nis_busy_if;
  logic start;
  logic [`NIS_CNT_W-1:0] len;
  logic [`NIS_CNT_W-1:0] mark;
  logic busy;
  logic mark_hit;
  logic done;
  modport ctrl (output start, output len, output mark, input busy, input mark_hit, input done);
  modport tmr (input start, input len, input mark, output busy, output mark_hit, output done);
endinterface : nis_busy_if

/* File: nis_busy_tmr.sv */
// Busy timer of one target: counts the busy time and flags a mid-point
`timescale 1ns/100ps
`include "nis_map.svh"
module nis_busy_tmr (
  input logic clk, // System clock
  input logic rst_b, // Asynchronous reset, active low
  nis_busy_if.tmr bif // Start, length, mid-point and results
);
  nis_pkg::nis_tmr_t st_reg;
  nis_pkg::nis_tmr_t st_next;

  // A new start aborts a running count, as a reset aborts an operation
  always_comb begin
    st_next = st_reg;
    st_next.mark_hit = 1'b0;
    st_next.done = 1'b0;
    if (bif.start) begin
      st_next.busy = 1'b1;
      st_next.cnt = '0;
    end else if (st_reg.busy) begin
      st_next.cnt = st_reg.cnt + 1'b1;
      if (st_next.cnt == bif.mark) begin
        st_next.mark_hit = 1'b1;
      end
      if (st_next.cnt == bif.len) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Results straight from the register
  assign bif.busy = st_reg.busy;
  assign bif.mark_hit = st_reg.mark_hit;
  assign bif.done = st_reg.done;
endmodule : nis_busy_tmr

/* File: nis_ctrl.sv */
// Target control: power-on reset, interface switching and opcode decode
`timescale 1ns/100ps
`include "nis_map.svh"
module nis_ctrl #(
  parameter int N = `NIS_TARGETS, // Number of targets
  parameter int POR_CYC = `NIS_POR_CYC, // Power-on reset busy cycles
  parameter int RST_CYC = `NIS_RST_CYC, // Reset busy cycles
  parameter int ITC_CYC = `NIS_ITC_CYC // Interface change cycles
) (
  input logic clk, // System clock, 40 MHz
  input logic rst_b, // Asynchronous reset, active low
  input logic [N-1:0] ce_b, // Target selects, active low
  input logic cle, // Command latch enable
  input logic ale, // Address latch enable
  input logic we_clk, // Write strobe or bus clock
  input logic re_b, // Read strobe or write/read select
  input logic [7:0] dq_in, // Data bus in
  output logic [7:0] dq_out, // Data bus out
  output logic dq_oe, // Data bus drive enable
  output logic [N-1:0] ready_busy_b, // High ready, low busy
  output logic [N-1:0] sync_mode, // Synchronous interface active
  output logic [4*N-1:0] timing_mode, // Timing mode per target
  output logic op_valid, // Decoded operation pulse
  output nis_pkg::nis_op_t op_code, // Decoded operation
  output logic [((N > 1) ? $clog2(N) : 1)-1:0] op_target // Target of it
);
  localparam int TW = (N > 1) ? $clog2(N) : 1;
  localparam int PW = N + 12;
  localparam int CW = `NIS_CNT_W;
  localparam int A_REV_MAX = ITC_CYC + 4;

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic we_d;
    nis_pkg::nis_tgt_t [N-1:0] tg;
    logic [N-1:0] rb;
    logic [7:0] dq_out;
    logic dq_oe;
    logic op_valid;
    nis_pkg::nis_op_t op_code;
    logic [TW-1:0] op_tgt;
  } nis_state_t;

  nis_state_t st_reg;
  nis_state_t st_next;
  logic [N-1:0] t_busy;
  logic [N-1:0] t_mark;
  logic [N-1:0] t_done;

  // Confirm opcode of a two-cycle command, OP_NONE when it does not fit
  function automatic nis_pkg::nis_op_t conf_op(input logic [7:0] c1, input logic [7:0] c2);
    conf_op = nis_pkg::OP_NONE;
    if (c1 == `NIS_OP_READ) begin
      if (c2 == `NIS_OP_RCONF) conf_op = nis_pkg::OP_PAGE_READ;
      else if (c2 == `NIS_OP_CSEQ) conf_op = nis_pkg::OP_CACHE_RAND;
      else if (c2 == `NIS_OP_RMP) conf_op = nis_pkg::OP_READ_MP;
    end else if (c1 == `NIS_OP_CCOL || c1 == `NIS_OP_CCOLE) begin
      if (c2 == `NIS_OP_CCONF) begin
        conf_op = (c1 == `NIS_OP_CCOLE) ? nis_pkg::OP_CHG_COL_ENH : nis_pkg::OP_CHG_COL;
      end
    end else if (c1 == `NIS_OP_PROG) begin
      if (c2 == `NIS_OP_PCONF) conf_op = nis_pkg::OP_PROG;
      else if (c2 == `NIS_OP_PMP) conf_op = nis_pkg::OP_PROG_MP;
      else if (c2 == `NIS_OP_PCACHE) conf_op = nis_pkg::OP_PROG_CACHE;
    end
  endfunction : conf_op

  // Pins pass two flops; each target keeps its own state and timer
  always_comb begin
    logic [7:0] c;
    logic [7:0] stat;
    logic wr, live, is_cmd, is_adr, is_din, bsy, ok, rd;
    nis_pkg::nis_tgt_t t;
    nis_pkg::nis_op_t op;
    c = st_reg.s2[7:0];
    stat = '0;
    live = 1'b0;
    is_cmd = 1'b0;
    is_adr = 1'b0;
    is_din = 1'b0;
    bsy = 1'b0;
    ok = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    t = '0;
    op = nis_pkg::OP_NONE;
    st_next = st_reg;
    st_next.s1 = {ce_b, cle, ale, we_clk, re_b, dq_in};
    st_next.s2 = st_reg.s1;
    st_next.we_d = st_reg.s2[`NIS_PIN_WE];
    // Same rising edge latches asynchronous writes and synchronous cycles
    wr = st_reg.s2[`NIS_PIN_WE] & ~st_reg.we_d & st_reg.s2[`NIS_PIN_RE];
    st_next.op_valid = 1'b0;
    st_next.op_code = nis_pkg::OP_NONE;
    st_next.op_tgt = '0;
    st_next.dq_oe = 1'b0;
    st_next.dq_out = '0;
    // Descending so the lowest selected target wins the shared outputs
    for (int i = N - 1; i >= 0; i--) begin
      t = st_reg.tg[i];
      t.start = 1'b0;
      op = nis_pkg::OP_NONE;
      live = wr & ~st_reg.s2[`NIS_PIN_CE + i];
      is_cmd = live & st_reg.s2[`NIS_PIN_CLE] & ~st_reg.s2[`NIS_PIN_ALE];
      is_adr = live & st_reg.s2[`NIS_PIN_ALE] & ~st_reg.s2[`NIS_PIN_CLE];
      // One byte per clock rising edge; the falling copy is identical
      is_din = live & (t.sync_mode ? (st_reg.s2[`NIS_PIN_CLE] & st_reg.s2[`NIS_PIN_ALE]) :
                       ~(st_reg.s2[`NIS_PIN_CLE] | st_reg.s2[`NIS_PIN_ALE]));
      bsy = t_busy[i] | st_reg.tg[i].start;
      // Interface change point inside a reset from synchronous mode
      if (t_mark[i] && t.to_async) begin
        t.sync_mode = 1'b0;
      end
      if (t_done[i]) begin
        if (t.kind == nis_pkg::BK_ITC) begin
          t.p1 = t.fbyte;
          t.sync_mode = (t.fbyte[7:4] == `NIS_P1_SYNC);
        end
        if (t.to_async) begin
          t.p1 = '0;
        end
        t.to_async = 1'b0;
        t.kind = nis_pkg::BK_NONE;
      end
      if (is_cmd) begin
        ok = (!bsy || c == `NIS_OP_RESET || c == `NIS_OP_SRESET || c == `NIS_OP_LRESET ||
              c == `NIS_OP_STAT || c == `NIS_OP_STATE) && (t.booted || c == `NIS_OP_RESET);
        if (ok) begin
          t.stat_sel = 1'b0;
          if ((t.seq == nis_pkg::SQ_WAIT2 || t.seq == nis_pkg::SQ_DATA) &&
              conf_op(t.cmd1, c) != nis_pkg::OP_NONE) begin
            op = conf_op(t.cmd1, c);
            t.seq = nis_pkg::SQ_IDLE;
          end else begin
            // Any other opcode aborts a pending sequence and starts anew
            t.seq = nis_pkg::SQ_IDLE;
            t.cmd1 = c;
            t.acnt = '0;
            if (c == `NIS_OP_RESET) begin
              t.start = 1'b1;
              t.len = t.booted ? CW'(RST_CYC) : CW'(POR_CYC);
              t.kind = t.booted ? nis_pkg::BK_RST : nis_pkg::BK_POR;
              t.to_async = t.sync_mode;
              t.booted = 1'b1;
              op = nis_pkg::OP_RESET;
            end else if (c == `NIS_OP_SRESET) begin
              if (t.sync_mode) begin
                t.start = 1'b1;
                t.len = CW'(RST_CYC);
                t.kind = nis_pkg::BK_RST;
                op = nis_pkg::OP_SYNC_RESET;
              end
            end else if (c == `NIS_OP_STAT) begin
              t.stat_sel = 1'b1;
              op = nis_pkg::OP_STATUS;
            end else if (c == `NIS_OP_CSEQ) begin
              op = nis_pkg::OP_CACHE_SEQ;
            end else if (c == `NIS_OP_CLAST) begin
              op = nis_pkg::OP_CACHE_LAST;
            end else if (c == `NIS_OP_READ || c == `NIS_OP_PROG || c == `NIS_OP_CCOLE) begin
              t.need = 3'd5;
              t.seq = nis_pkg::SQ_ADDR;
            end else if (c == `NIS_OP_CCOL) begin
              t.need = 3'd2;
              t.seq = nis_pkg::SQ_ADDR;
            end else if (c == `NIS_OP_STATE || c == `NIS_OP_LRESET) begin
              t.need = 3'd3;
              t.seq = nis_pkg::SQ_ADDR;
            end else if (c == `NIS_OP_SETF) begin
              t.need = 3'd1;
              t.seq = nis_pkg::SQ_ADDR;
            end
          end
        end
      end else if (is_adr && t.seq == nis_pkg::SQ_ADDR) begin
        t.acnt = t.acnt + 3'd1;
        if (t.acnt == t.need) begin
          t.seq = nis_pkg::SQ_IDLE;
          if (t.cmd1 == `NIS_OP_STATE) begin
            t.stat_sel = 1'b1;
            op = nis_pkg::OP_STATUS_ENH;
          end else if (t.cmd1 == `NIS_OP_LRESET) begin
            t.start = 1'b1;
            t.len = CW'(RST_CYC);
            t.kind = nis_pkg::BK_RST;
            op = nis_pkg::OP_RESET_LUN;
          end else if (t.cmd1 == `NIS_OP_SETF) begin
            t.feat_tm = (c == `NIS_FA_TIMING);
            t.dcnt = '0;
            t.seq = nis_pkg::SQ_DATA;
          end else if (t.cmd1 == `NIS_OP_PROG) begin
            t.seq = nis_pkg::SQ_DATA;
          end else begin
            t.seq = nis_pkg::SQ_WAIT2;
          end
        end
      end else if (is_din && t.seq == nis_pkg::SQ_DATA && t.cmd1 == `NIS_OP_SETF) begin
        t.dcnt = t.dcnt + 3'd1;
        if (t.dcnt == 3'd1) begin
          t.fbyte = c;
        end
        // Upper three parameters carry nothing for the timing feature
        if (t.dcnt == 3'd4) begin
          t.seq = nis_pkg::SQ_IDLE;
          op = nis_pkg::OP_SET_FEAT;
          if (t.feat_tm) begin
            t.start = 1'b1;
            t.len = CW'(ITC_CYC);
            t.kind = nis_pkg::BK_ITC;
          end
        end
      end
      // Ready drops in the cycle a timer start is issued
      st_next.rb[i] = ~(t.start | st_reg.tg[i].start | t_busy[i]);
      if (op != nis_pkg::OP_NONE) begin
        st_next.op_valid = 1'b1;
        st_next.op_code = op;
        st_next.op_tgt = TW'(i);
      end
      // Status byte drives the bus only while a status read is armed
      if (!st_reg.s2[`NIS_PIN_CE + i]) begin
        rd = ~st_reg.s2[`NIS_PIN_RE] &
             (~st_reg.tg[i].sync_mode | (st_reg.s2[`NIS_PIN_CLE] & st_reg.s2[`NIS_PIN_ALE]));
        stat = '0;
        stat[`NIS_SR_WPN] = 1'b1;
        stat[`NIS_SR_RDY] = ~bsy;
        stat[`NIS_SR_ARDY] = ~bsy;
        st_next.dq_oe = rd & st_reg.tg[i].stat_sel;
        st_next.dq_out = stat;
      end
      st_next.tg[i] = t;
    end
  end

  // State register; reset selects asynchronous mode on every target
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // One busy timer per target
  for (genvar i = 0; i < N; i++) begin : g_tgt
    nis_busy_if bif ();
    assign bif.start = st_reg.tg[i].start;
    assign bif.len = st_reg.tg[i].len;
    assign bif.mark = CW'(ITC_CYC);
    assign t_busy[i] = bif.busy;
    assign t_mark[i] = bif.mark_hit;
    assign t_done[i] = bif.done;
    assign sync_mode[i] = st_reg.tg[i].sync_mode;
    assign timing_mode[4*i +: 4] = st_reg.tg[i].p1[3:0];
    nis_busy_tmr u_tmr (
      .clk(clk),
      .rst_b(rst_b),
      .bif(bif)
    );
  end

  // Outputs straight from the register
  assign ready_busy_b = st_reg.rb;
  assign dq_out = st_reg.dq_out;
  assign dq_oe = st_reg.dq_oe;
  assign op_valid = st_reg.op_valid;
  assign op_code = st_reg.op_code;
  assign op_target = st_reg.op_tgt;

  // Command cycle seen by target 0, for the checks below
  logic a_cmd0;
  logic [7:0] a_c;
  assign a_c = st_reg.s2[7:0];
  assign a_cmd0 = st_reg.s2[`NIS_PIN_WE] & ~st_reg.we_d & st_reg.s2[`NIS_PIN_RE] &
                  ~st_reg.s2[`NIS_PIN_CE] & st_reg.s2[`NIS_PIN_CLE] & ~st_reg.s2[`NIS_PIN_ALE];

  default clocking a_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_boot_async: assert property (!st_reg.tg[0].booted |-> !sync_mode[0])
    else $error("target 0 left asynchronous mode before first reset");
  a_por_busy: assert property ((a_cmd0 && a_c == `NIS_OP_RESET && !st_reg.tg[0].booted)
    |=> !ready_busy_b[0] [*4]) else $error("power-on reset did not hold busy");
  a_busy_ignore: assert property ((a_cmd0 && t_busy[0] && !(a_c inside {`NIS_OP_RESET, `NIS_OP_SRESET,
    `NIS_OP_LRESET, `NIS_OP_STAT, `NIS_OP_STATE}))
    |=> !(op_valid && op_target == '0)) else $error("busy target accepted an opcode");
  a_busy_status: assert property ((a_cmd0 && t_busy[0] && a_c == `NIS_OP_STAT && st_reg.tg[0].booted)
    |=> op_valid && op_code == nis_pkg::OP_STATUS) else $error("status read refused while busy");
  a_sync_revert: assert property ((a_cmd0 && a_c == `NIS_OP_RESET && sync_mode[0])
    |-> ##[1:A_REV_MAX] !sync_mode[0]) else $error("reset did not revert to asynchronous");
  a_rst_end_p1: assert property ((t_done[0] && st_reg.tg[0].to_async)
    |=> timing_mode[3:0] == 4'h0 && !sync_mode[0] && ready_busy_b[0]) else $error("reset end state wrong");
  a_itc_raise: assert property ((t_done[0] && st_reg.tg[0].kind == nis_pkg::BK_ITC && !a_cmd0 &&
    st_reg.tg[0].fbyte[7:4] == `NIS_P1_SYNC) |=> sync_mode[0] && ready_busy_b[0])
    else $error("interface change end did not enable synchronous mode");
  a_setf_busy: assert property ((op_valid && op_code == nis_pkg::OP_SET_FEAT && op_target == '0 &&
    st_reg.tg[0].kind == nis_pkg::BK_ITC) |-> !ready_busy_b[0]) else $error("no busy after set features");
  a_cache_seq: assert property ((a_cmd0 && a_c == `NIS_OP_CSEQ && st_reg.tg[0].seq == nis_pkg::SQ_IDLE &&
    !t_busy[0] && !st_reg.tg[0].start && st_reg.tg[0].booted) |=> op_code == nis_pkg::OP_CACHE_SEQ)
    else $error("cache sequential read not decoded");
  a_chg_col: assert property ((a_cmd0 && a_c == `NIS_OP_CCONF && st_reg.tg[0].seq == nis_pkg::SQ_WAIT2 &&
    st_reg.tg[0].cmd1 == `NIS_OP_CCOLE && !t_busy[0] && !st_reg.tg[0].start)
    |=> op_code == nis_pkg::OP_CHG_COL_ENH) else $error("enhanced column change not decoded");
endmodule : nis_ctrl

/* File: nis_host_model.sv */
// Host controller model driving the target pins
`timescale 1ns/100ps
module nis_host_model #(
  parameter int N = 2 // Number of targets
) (
  input logic clk, // System clock
  output logic [N-1:0] ce_b, // Target selects, active low
  output logic cle, // Command latch enable
  output logic ale, // Address latch enable
  output logic we_clk, // Write strobe or bus clock
  output logic re_b, // Read strobe, active low
  output logic [7:0] dq_in // Data bus toward the target
);
  logic sync_on; // Host port runs synchronous cycles
  // Idle pins from time zero: deselected, async strobe high
  initial begin
    ce_b = '1;
    cle = 1'b0;
    ale = 1'b0;
    we_clk = 1'b1;
    re_b = 1'b1;
    dq_in = 8'h00;
    sync_on = 1'b0;
  end
  // All pin changes land just after a clock edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  // Select one target alone
  task automatic sel(input int t);
    step(1);
    ce_b = ~(N'(1) << t);
    step(2);
  endtask : sel
  // Deselect before the clock stops, then change port kind
  task automatic port_mode(input logic s);
    step(1);
    ce_b = '1;
    step(3);
    sync_on = s;
    we_clk = ~s; // Clock stands still low between sync frames
    step(2);
  endtask : port_mode
  // One latched cycle of 200 ns, byte held over both strobe edges
  task automatic cyc(input int kind, input logic [7:0] b);
    cle = (kind == 0) || (kind == 2 && sync_on);
    ale = (kind == 1) || (kind == 2 && sync_on);
    dq_in = b;
    step(2);
    we_clk = sync_on;
    step(3);
    we_clk = ~sync_on;
    step(2);
    cle = 1'b0;
    ale = 1'b0;
    dq_in = ~b; // Released bus must not keep the last byte
    step(1); // Next cycle never lands in the release time step
  endtask : cyc
  // Command, addresses, data and optional confirm (00h means none)
  task automatic op(input int t, input logic [7:0] c1, input int na, input int nd, input logic [7:0] c2);
    sel(t);
    cyc(0, c1);
    for (int i = 0; i < na; i++) cyc(1, 8'(i));
    for (int i = 0; i < nd; i++) cyc(2, 8'(8'ha5 + i));
    if (c2 != 8'h00) cyc(0, c2);
  endtask : op
  // Timing feature write, then deselect and stay silent
  task automatic set_feat(input int t, input logic [7:0] p1);
    sel(t);
    cyc(0, 8'hef);
    cyc(1, 8'h01);
    cyc(2, p1);
    for (int i = 0; i < 3; i++) cyc(2, 8'h00);
    step(1);
    ce_b = '1;
  endtask : set_feat
  // Read strobe level for status reads
  task automatic read_hold(input logic lo);
    step(1);
    re_b = ~lo;
  endtask : read_hold
endmodule : nis_host_model

/* File: nand_init_interface_select_tb_top.sv */
// Testbench of the target control block with a host model
`timescale 1ns/100ps
module nand_init_interface_select_tb_top;
  localparam int N = 2;
  localparam int POR = 120; // Shortened busy times keep the run short
  localparam int RST = 100;
  localparam int ITC = 10;
  logic clk;
  logic rst_b;
  logic [N-1:0] ce_b;
  logic cle;
  logic ale;
  logic we_clk;
  logic re_b;
  logic [7:0] dq_in;
  logic [7:0] dq_out;
  logic dq_oe;
  logic [N-1:0] ready_busy_b;
  logic [N-1:0] sync_mode;
  logic [4*N-1:0] timing_mode;
  logic op_valid;
  nis_pkg::nis_op_t op_code;
  logic [0:0] op_target;
  int bad_count = 0;
  int tests_run = 0;
  int op_cnt = 0;
  nis_pkg::nis_op_t last_op;
  logic last_tgt;
  int low_run[N] = '{default: 0};
  int low_len[N] = '{default: 0};
  nis_ctrl #(.N(N), .POR_CYC(POR), .RST_CYC(RST), .ITC_CYC(ITC)) u_dut (.clk(clk), .rst_b(rst_b), .ce_b(ce_b),
    .cle(cle), .ale(ale), .we_clk(we_clk), .re_b(re_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .ready_busy_b(ready_busy_b), .sync_mode(sync_mode), .timing_mode(timing_mode), .op_valid(op_valid),
    .op_code(op_code), .op_target(op_target));
  nis_host_model #(.N(N)) u_host (.clk(clk), .ce_b(ce_b), .cle(cle), .ale(ale), .we_clk(we_clk), .re_b(re_b),
    .dq_in(dq_in));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Decoded pulses and busy stretches, caught where they stand for one cycle
  always @(posedge clk) begin
    if (op_valid === 1'b1) begin
      op_cnt <= op_cnt + 1;
      last_op <= op_code;
      last_tgt <= op_target[0];
    end
    for (int t = 0; t < N; t++) begin
      if (ready_busy_b[t] === 1'b0) low_run[t] <= low_run[t] + 1;
      else if (low_run[t] != 0) begin
        low_len[t] <= low_run[t];
        low_run[t] <= 0;
      end
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Send one sequence; OP_NONE means it must be dropped
  task automatic run_op(input int t, input logic [7:0] c1, input int na, input int nd, input logic [7:0] c2,
    input nis_pkg::nis_op_t exp);
    int n0;
    n0 = op_cnt;
    u_host.op(t, c1, na, nd, c2);
    repeat (3) @(posedge clk);
    #2;
    check("op count", op_cnt - n0, (exp == nis_pkg::OP_NONE) ? 0 : 1);
    if (exp != nis_pkg::OP_NONE) begin
      check("op code", last_op, exp);
      check("op target", last_tgt, t[0]);
    end
  endtask : run_op
  // Status byte on the bus while the read strobe is low
  task automatic status_read(input logic rdy);
    u_host.read_hold(1'b1);
    repeat (8) @(posedge clk);
    #2;
    check("status", {dq_oe, dq_out[7:5]}, {1'b1, 1'b1, rdy, rdy});
    u_host.read_hold(1'b0);
    repeat (2) @(posedge clk);
  endtask : status_read
  // Bounded wait for ready, then the busy stretch is judged against lo
  task automatic wait_ready(input int t, input int lo);
    int i;
    for (i = 0; i < 2000 && ready_busy_b[t] !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #2;
    check("busy length", (low_len[t] >= lo) && (low_len[t] <= lo + 3), 1'b1);
  endtask : wait_ready
  // Power-on state, refusal before the first reset, power-on busy
  task automatic t_power_on();
    check("ready", ready_busy_b, 2'b11);
    check("sync", sync_mode, 2'b00);
    check("timing", timing_mode, 8'h00);
    run_op(0, 8'h70, 0, 0, 8'h00, nis_pkg::OP_NONE);
    run_op(0, 8'hff, 0, 0, 8'h00, nis_pkg::OP_RESET);
    run_op(0, 8'h70, 0, 0, 8'h00, nis_pkg::OP_STATUS);
    status_read(1'b0);
    run_op(0, 8'h31, 0, 0, 8'h00, nis_pkg::OP_NONE);
    wait_ready(0, POR);
    status_read(1'b1);
    run_op(1, 8'hff, 0, 0, 8'h00, nis_pkg::OP_RESET);
    wait_ready(1, POR);
  endtask : t_power_on
  // Synchronous interface on target 0 only, timing mode 2
  task automatic t_set_sync();
    int n0;
    n0 = op_cnt;
    u_host.set_feat(0, 8'h12);
    repeat (3) @(posedge clk);
    check("feature op", {24'(op_cnt - n0), 8'(last_op)}, {24'd1, 8'(nis_pkg::OP_SET_FEAT)});
    wait_ready(0, ITC);
    check("sync per target", sync_mode, 2'b01);
    check("timing per target", timing_mode, 8'h02);
  endtask : t_set_sync
  // Every read, program, column-change and cache form, target 0 in sync cycles and target 1 in async cycles
  task automatic t_decode();
    logic [7:0] c1[10] = '{8'h05, 8'h06, 8'h31, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
    logic [7:0] c2[10] = '{8'he0, 8'he0, 8'h00, 8'h00, 8'h31, 8'h30, 8'h32, 8'h10, 8'h11, 8'h15};
    int na[10] = '{2, 5, 0, 0, 5, 5, 5, 5, 5, 5};
    nis_pkg::nis_op_t ex[10] = '{nis_pkg::OP_CHG_COL, nis_pkg::OP_CHG_COL_ENH, nis_pkg::OP_CACHE_SEQ,
      nis_pkg::OP_CACHE_LAST, nis_pkg::OP_CACHE_RAND, nis_pkg::OP_PAGE_READ, nis_pkg::OP_READ_MP,
      nis_pkg::OP_PROG, nis_pkg::OP_PROG_MP, nis_pkg::OP_PROG_CACHE};
    for (int t = 0; t < N; t++) begin
      u_host.port_mode(t == 0);
      for (int i = 0; i < 10; i++) run_op(t, c1[i], na[i], (i > 6) ? 2 : 0, c2[i], ex[i]);
    end
  endtask : t_decode
  // Back to async by reset from sync; status polled inside the reset busy time
  task automatic t_back_async();
    u_host.port_mode(1'b0);
    run_op(0, 8'hff, 0, 0, 8'h00, nis_pkg::OP_RESET);
    check("busy after reset", ready_busy_b[0], 1'b0);
    repeat (ITC + 4) @(posedge clk);
    check("async in busy", sync_mode[0], 1'b0);
    run_op(0, 8'h70, 0, 0, 8'h00, nis_pkg::OP_STATUS);
    run_op(0, 8'h78, 3, 0, 8'h00, nis_pkg::OP_STATUS_ENH);
    status_read(1'b0);
    wait_ready(0, RST);
    check("mode cleared", {sync_mode, timing_mode}, {2'b00, 8'h00});
    status_read(1'b1);
  endtask : t_back_async
  task automatic results();
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Watchdog well beyond the 1600 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    t_power_on();
    t_set_sync();
    t_decode();
    t_back_async();
    results();
  end
endmodule : nand_init_interface_select_tb_top
